// ---- core/mise_alu.v ----
`timescale 1ns/10ps
`include "mise_consts.vh"
// Combinational result and flag generation for one instruction
module mise_alu (
	input  wire [2:0] op_in,
	input  wire [7:0] acc_in,
	input  wire [7:0] reg_in,
	input  wire [7:0] imm_in,
	input  wire [7:0] tmode_in,
	output reg  [7:0] result_out,
	output reg        z_out,
	output reg        dcy_out,
	output reg        c_out,
	output reg        upd_z_out,
	output reg        upd_dcc_out
);
	reg [8:0] sum;
	reg [4:0] nib;

	// Result select; subtraction is imm + ~acc + 1 so carry means no borrow
	always @* begin
		sum         = 9'h000;
		nib         = 5'h00;
		result_out  = acc_in;
		upd_z_out   = 1'b0;
		upd_dcc_out = 1'b0;
		case (op_in)
			`MISE_OP_SUB_IMM: begin
				sum         = {1'b0, imm_in} + {1'b0, ~acc_in} + 9'h001;
				nib         = {1'b0, imm_in[3:0]} + {1'b0, ~acc_in[3:0]} + 5'h01;
				result_out  = sum[7:0];
				upd_z_out   = 1'b1;
				upd_dcc_out = 1'b1;
			end
			`MISE_OP_SWAP: begin
				result_out = {reg_in[3:0], reg_in[7:4]};
			end
			`MISE_OP_TMODE_READ: begin
				result_out = tmode_in;
			end
			`MISE_OP_XOR_REG: begin
				result_out = acc_in ^ reg_in;
				upd_z_out  = 1'b1;
			end
			`MISE_OP_XOR_IMM: begin
				result_out = acc_in ^ imm_in;
				upd_z_out  = 1'b1;
			end
			default: begin
				result_out = acc_in;
			end
		endcase
		z_out   = (result_out == 8'h00);
		c_out   = sum[8];
		dcy_out = nib[4];
	end
endmodule // mise_alu

// ---- core/mise_consts.vh ----
`ifndef MISE_CONSTS_VH
`define MISE_CONSTS_VH
// Operation select codes presented with each instruction
`define MISE_OP_W          3
`define MISE_OP_HALT       3'h0
`define MISE_OP_SUB_IMM    3'h1
`define MISE_OP_SWAP       3'h2
`define MISE_OP_TMODE_LOAD 3'h3
`define MISE_OP_TMODE_READ 3'h4
`define MISE_OP_TABLE_READ 3'h5
`define MISE_OP_XOR_REG    3'h6
`define MISE_OP_XOR_IMM    3'h7
// Reset values
`define MISE_ACC_RST       8'h00
`define MISE_TMODE_RST     8'h00
`define MISE_TDH_RST       6'h00
`define MISE_WDT_CLR       8'h00
// Destination bit meaning
`define MISE_DEST_ACC      1'b0
// Cycle counts
`define MISE_TABLE_CYCLES  2
`define MISE_ONE_CYCLE     1
// ROM geometry
`define MISE_ROM_AW        11
`define MISE_ROM_DW        14
`endif

// ---- core/mise_exec.v ----
`timescale 1ns/10ps
`include "mise_consts.vh"
// Behaviour
// - Halt clears watchdog counter and prescaler, one cycle.
// - Halt sets timeout flag, clears powerdown flag, requests halt mode.
// - Immediate minus acc into acc, updates zero, digit carry, carry; one cycle.
// - Nibble swap of register 0..127, no flags, one cycle.
// - Destination bit 0 writes acc, 1 writes back the register.
// - Acc loads the timer-0 mode register, flags kept, one cycle.
// - Timer-0 mode register copied to acc, flags kept, one cycle.
// - Table read of {pointer[2:0],acc}: low to acc, high to data-high; two cycles.
// - Acc xor register routed by destination bit, zero flag only.
// - Acc xor immediate into acc, zero flag only, one cycle.
module mise_exec #(
	parameter ROM_AW = `MISE_ROM_AW,
	parameter ROM_DW = `MISE_ROM_DW
) (
	input  wire              core_clk_in,
	input  wire              rst_b_in,
	input  wire              clk_en_in,
	input  wire              instr_valid_in,
	input  wire [2:0]        op_in,
	input  wire [7:0]        imm_in,
	input  wire [6:0]        reg_addr_in,
	input  wire              dest_in,
	input  wire [7:0]        reg_rdata_in,
	input  wire [7:0]        table_pointer_high_in,
	input  wire [ROM_DW-1:0] rom_data_in,
	output wire              busy_out,
	output reg  [7:0]        acc_out,
	output reg  [7:0]        timer0_mode_reg_out,
	output reg               timer0_mode_wr_out,
	output reg  [5:0]        table_data_high_out,
	output reg  [ROM_AW-1:0] rom_addr_out,
	output reg               rom_rd_out,
	output reg  [6:0]        reg_waddr_out,
	output reg  [7:0]        reg_wdata_out,
	output reg               reg_we_out,
	output reg               zero_flag_out,
	output reg               digit_carry_flag_out,
	output reg               carry_flag_out,
	output reg               timeout_flag_out,
	output reg               powerdown_flag_out,
	output reg               wdt_clear_out,
	output reg               halt_req_out
);
	reg        rst_s1_q;
	reg        rst_s2_q;
	wire       rst_b;
	reg        tbl_wait_q;
	wire [7:0] alu_res;
	wire       alu_z;
	wire       alu_dcy;
	wire       alu_c;
	wire       upd_z;
	wire       upd_dcc;
	wire       go;
	wire       to_acc;

	// Reset released through two flops so removal is clean to this clock
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign rst_b = rst_s2_q;

	// New instruction refused while the table read holds its second cycle
	assign busy_out = tbl_wait_q;
	assign go       = instr_valid_in & clk_en_in & ~tbl_wait_q;

	assign to_acc = (op_in == `MISE_OP_SUB_IMM) | (op_in == `MISE_OP_XOR_IMM) |
	                (op_in == `MISE_OP_TMODE_READ) |
	                (((op_in == `MISE_OP_SWAP) | (op_in == `MISE_OP_XOR_REG)) &
	                 (dest_in == `MISE_DEST_ACC));

	mise_alu u_alu (
		.op_in       (op_in),
		.acc_in      (acc_out),
		.reg_in      (reg_rdata_in),
		.imm_in      (imm_in),
		.tmode_in    (timer0_mode_reg_out),
		.result_out  (alu_res),
		.z_out       (alu_z),
		.dcy_out     (alu_dcy),
		.c_out       (alu_c),
		.upd_z_out   (upd_z),
		.upd_dcc_out (upd_dcc)
	);

	// Execution state; pulses are cleared each enabled cycle
	always @(posedge core_clk_in or negedge rst_b) begin
		if (!rst_b) begin
			acc_out              <= `MISE_ACC_RST;
			timer0_mode_reg_out  <= `MISE_TMODE_RST;
			timer0_mode_wr_out   <= 1'b0;
			table_data_high_out  <= `MISE_TDH_RST;
			rom_addr_out         <= {ROM_AW{1'b0}};
			rom_rd_out           <= 1'b0;
			reg_waddr_out        <= 7'h00;
			reg_wdata_out        <= 8'h00;
			reg_we_out           <= 1'b0;
			zero_flag_out        <= 1'b0;
			digit_carry_flag_out <= 1'b0;
			carry_flag_out       <= 1'b0;
			timeout_flag_out     <= 1'b1;
			powerdown_flag_out   <= 1'b1;
			wdt_clear_out        <= 1'b0;
			halt_req_out         <= 1'b0;
			tbl_wait_q           <= 1'b0;
		end else if (clk_en_in) begin
			timer0_mode_wr_out <= 1'b0;
			reg_we_out         <= 1'b0;
			wdt_clear_out      <= 1'b0;
			halt_req_out       <= 1'b0;
			rom_rd_out         <= 1'b0;
			if (tbl_wait_q) begin
				acc_out             <= rom_data_in[7:0];
				table_data_high_out <= rom_data_in[13:8];
				tbl_wait_q          <= 1'b0;
			end else if (go) begin
				case (op_in)
					`MISE_OP_HALT: begin
						wdt_clear_out      <= 1'b1;
						timeout_flag_out   <= 1'b1;
						powerdown_flag_out <= 1'b0;
						halt_req_out       <= 1'b1;
					end
					`MISE_OP_TMODE_LOAD: begin
						timer0_mode_reg_out <= acc_out;
						timer0_mode_wr_out  <= 1'b1;
					end
					`MISE_OP_TABLE_READ: begin
						rom_addr_out <= {table_pointer_high_in[2:0], acc_out};
						rom_rd_out   <= 1'b1;
						tbl_wait_q   <= 1'b1;
					end
					default: begin
						if (to_acc) begin
							acc_out <= alu_res;
						end else begin
							reg_waddr_out <= reg_addr_in;
							reg_wdata_out <= alu_res;
							reg_we_out    <= 1'b1;
						end
						if (upd_z) begin
							zero_flag_out <= alu_z;
						end
						if (upd_dcc) begin
							digit_carry_flag_out <= alu_dcy;
							carry_flag_out       <= alu_c;
						end
					end
				endcase
			end
		end
	end
endmodule // mise_exec

// ---- tb/mise_exec_asserts.sv ----
`timescale 1ns/10ps
// Port-level properties of the executer
module mise_chk (
	input wire core_clk_in,
	input wire rst_b_in,
	input wire clk_en_in,
	input wire instr_valid_in,
	input wire [2:0] op_in,
	input wire [7:0] imm_in,
	input wire [6:0] reg_addr_in,
	input wire dest_in,
	input wire [7:0] reg_rdata_in,
	input wire [7:0] table_pointer_high_in,
	input wire busy_out,
	input wire [7:0] acc_out,
	input wire [7:0] timer0_mode_reg_out,
	input wire timer0_mode_wr_out,
	input wire [10:0] rom_addr_out,
	input wire rom_rd_out,
	input wire [6:0] reg_waddr_out,
	input wire [7:0] reg_wdata_out,
	input wire reg_we_out,
	input wire zero_flag_out,
	input wire digit_carry_flag_out,
	input wire carry_flag_out,
	input wire timeout_flag_out,
	input wire powerdown_flag_out,
	input wire wdt_clear_out,
	input wire halt_req_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	// Accepted at this edge
	wire tk = instr_valid_in & clk_en_in & !busy_out;
	// Table read steps: fetch, then release
	sequence tbl_fetch;
		rom_rd_out && busy_out
		&& rom_addr_out == {$past(table_pointer_high_in[2:0]), $past(acc_out)};
	endsequence
	sequence tbl_done;
		!busy_out && !rom_rd_out;
	endsequence
	halt_fx_a: assert property (tk && op_in == 3'h0 |=>
		wdt_clear_out && halt_req_out && timeout_flag_out && !powerdown_flag_out)
		else $error("halt effects wrong");
	sub_imm_a: assert property (tk && op_in == 3'h1 |=>
		acc_out == $past(imm_in) - $past(acc_out) && zero_flag_out == (acc_out == 8'h00)
		&& carry_flag_out == ($past(imm_in) >= $past(acc_out))) else $error("subtract wrong");
	swap_back_a: assert property (tk && op_in == 3'h2 && dest_in |=> reg_we_out
		&& reg_waddr_out == $past(reg_addr_in) && $stable(zero_flag_out)
		&& reg_wdata_out == {$past(reg_rdata_in[3:0]), $past(reg_rdata_in[7:4])})
		else $error("swap wrong");
	tmode_load_a: assert property (tk && op_in == 3'h3 |=> timer0_mode_wr_out
		&& timer0_mode_reg_out == $past(acc_out) && $stable(carry_flag_out))
		else $error("mode load wrong");
	tmode_read_a: assert property (tk && op_in == 3'h4 |=>
		acc_out == $past(timer0_mode_reg_out) && $stable(zero_flag_out))
		else $error("mode read wrong");
	table_seq_a: assert property (tk && op_in == 3'h5 |=> tbl_fetch ##1 tbl_done)
		else $error("table read wrong");
	xor_acc_a: assert property (tk && op_in == 3'h6 && !dest_in |=> !reg_we_out
		&& acc_out == ($past(acc_out) ^ $past(reg_rdata_in)) && $stable(carry_flag_out))
		else $error("xor register wrong");
	xor_imm_a: assert property (tk && op_in == 3'h7 |=>
		acc_out == ($past(acc_out) ^ $past(imm_in)) && zero_flag_out == (acc_out == 8'h00))
		else $error("xor immediate wrong");
	sub_dcy_a: assert property (tk && op_in == 3'h1 |=>
		digit_carry_flag_out == ($past(imm_in[3:0]) >= $past(acc_out[3:0])))
		else $error("digit carry wrong");
	// Enable low must leave acc, the mode register and the zero and carry flags where they were
	freeze_hold_a: assert property (!clk_en_in |=> $stable(acc_out)
		&& $stable(timer0_mode_reg_out) && $stable(zero_flag_out) && $stable(carry_flag_out))
		else $error("freeze moved state");
endmodule // mise_chk
bind mise_exec mise_chk u_chk (.*);

// ---- tb/mise_exec_bench.sv ----
`timescale 1ns/10ps
module mise_exec_bench;
	reg core_clk_in = 0;
	reg rst_b_in = 0;
	reg clk_en_in = 1;
	reg instr_valid_in = 0;
	reg dest_in = 0;
	reg [2:0] op_in = 0;
	reg [7:0] imm_in = 0;
	reg [6:0] reg_addr_in = 0;
	reg [7:0] reg_rdata_in = 0;
	reg [7:0] table_pointer_high_in = 0;
	wire [13:0] rom_data_in;
	wire [10:0] rom_addr_out;
	wire [7:0] acc_out, timer0_mode_reg_out, reg_wdata_out;
	wire [6:0] reg_waddr_out;
	wire [5:0] table_data_high_out;
	wire busy_out, timer0_mode_wr_out, rom_rd_out, reg_we_out, zero_flag_out, halt_req_out;
	wire digit_carry_flag_out, carry_flag_out, timeout_flag_out, powerdown_flag_out;
	wire wdt_clear_out;
	integer n_errors = 0, checked = 0, seed = 51210, k, j, acc = 0, tm = 0, res;
	integer z = 0, c = 0, dcy = 0, tof = 1, pdf = 1;
	mise_exec u_dut (.*);
	// Table memory: the word is a fixed mix of its own address
	assign rom_data_in = {rom_addr_out[10:5], rom_addr_out[7:0] ^ 8'h5A};
	initial forever #2 core_clk_in = ~core_clk_in;
	task chk(input [63:0] nm, input [7:0] s, e);
		checked = checked + 1;
		if (s !== e) begin
			n_errors = n_errors + 1;
			$display("Error %0s exp %h got %h", nm, e, s);
		end
	endtask
	// Present one instruction, then compare with the model
	task run(input [2:0] o, input [7:0] i, r, input d);
		k = $random(seed);
		op_in = o;
		imm_in = i;
		reg_rdata_in = r;
		dest_in = d;
		reg_addr_in = k[6:0];
		table_pointer_high_in = k[15:8];
		instr_valid_in = 1;
		res = acc;
		@(negedge core_clk_in);
		case (o)
		0: begin
			tof = 1;
			pdf = 0;
			chk("halt", {wdt_clear_out, halt_req_out}, 8'h03);
		end
		1: begin
			res = (i - acc) & 255;
			c = i >= acc;
			dcy = i[3:0] >= acc[3:0];
		end
		2: res = {r[3:0], r[7:4]};
		3: begin
			tm = acc;
			chk("tmode", timer0_mode_reg_out, tm);
		end
		4: res = tm;
		5: begin
			// Offered during busy, so it must be dropped
			op_in = 7;
			imm_in = 8'hFF;
			chk("busy", busy_out, 8'h01);
			@(negedge core_clk_in);
			res = acc ^ 8'h5A;
			chk("tdhigh", table_data_high_out, {table_pointer_high_in[2:0], acc[7:5]});
		end
		6: res = acc ^ r;
		7: res = acc ^ i;
		endcase
		if (o == 1 || o > 5)
			z = res == 0;
		chk("we", reg_we_out, d && (o == 2 || o == 6));
		if (d && (o == 2 || o == 6))
			chk("wdata", reg_wdata_out, res);
		else
			acc = res;
		chk("acc", acc_out, acc);
		chk("flags", {zero_flag_out, digit_carry_flag_out, carry_flag_out, timeout_flag_out,
			powerdown_flag_out}, {z[0], dcy[0], c[0], tof[0], pdf[0]});
	endtask
	// Enable low with an instruction offered: no register may move
	task freeze;
		clk_en_in = 0;
		op_in = $random(seed);
		instr_valid_in = 1;
		@(negedge core_clk_in);
		chk("frz_acc", acc_out, acc);
		chk("frz_tm", timer0_mode_reg_out, tm);
		chk("frz_flg", {zero_flag_out, digit_carry_flag_out, carry_flag_out, timeout_flag_out,
			powerdown_flag_out}, {z[0], dcy[0], c[0], tof[0], pdf[0]});
		clk_en_in = 1;
	endtask
	task end_sim;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Reset, boundary subtractions, then a random stream
	initial begin
		repeat (5) @(negedge core_clk_in);
		chk("rst", {timeout_flag_out, powerdown_flag_out}, 8'h03);
		rst_b_in = 1;
		repeat (2) @(negedge core_clk_in);
		run(7, acc, 8'h00, 0);
		run(1, 8'h00, 8'h00, 0);
		run(7, 8'h06, 8'h00, 0);
		run(1, 8'h05, 8'h00, 0);
		run(2, 8'h00, 8'hA5, 1);
		$display("directed test done");
		for (j = 0; j < 600; j = j + 1) begin
			run($random(seed), $random(seed), $random(seed), $random(seed));
			if (j % 8 == 3)
				freeze;
		end
		$display("random test done");
		end_sim;
	end
endmodule // mise_exec_bench
